// *** src/rtc_pkg.sv ***
/*
 * Constants, field indices and carrier types for the BCD calendar clock.
 * Assumes one system clock of 50 MHz and a 32.768 kHz crystal level
 * presented as an ordinary input in that clock domain.
 */
`default_nettype none

// Overview of operation
// - Time, calendar and alarm are held as BCD, one digit per nibble.
// - Seconds, minutes, 24-hour hours, weekday, date, month, year carry; leap February.
// - Two-digit year spans one hundred years, 99 wraps to 00.
// - Alarm matches on second, minute, hour, day or week.
// - Periodic event every millisecond, second, minute, hour or day.
// - Alarm and periodic events share one interrupt output.
// - Time base is the 32.768 kHz crystal; counting rate is calibratable.
// - Writes are taken into the crystal domain; system clock at least 3x faster.
// - A written value takes effect two crystal cycles after the write.
// - Writes are ignored while the oscillator is disabled.
// - Block state is reset only by its own power-on reset.
// - System reset pin and core power-good never reset the block.
// - Counting and contents survive while the core is unpowered.
// - Alarm, periodic event or wake pin input wakes the processor.
// - Alarm or periodic event can be signalled on the wake pin.
// - Scratch entries are cleared only by the block's power-on reset.
// - Wake pin input is active high; as output it is open-drain active low.

package rtc_pkg;

   // ------------------------------------------------------------------
   // Entry indices of the value store
   // ------------------------------------------------------------------
   localparam int NUM_ENTRIES = 16;
   localparam logic [3:0] IDX_SEC = 4'h0;
   localparam logic [3:0] IDX_MIN = 4'h1;
   localparam logic [3:0] IDX_HOUR = 4'h2;
   localparam logic [3:0] IDX_DOW = 4'h3;
   localparam logic [3:0] IDX_DATE = 4'h4;
   localparam logic [3:0] IDX_MONTH = 4'h5;
   localparam logic [3:0] IDX_YEAR = 4'h6;
   localparam logic [3:0] IDX_ASEC = 4'h7;
   localparam logic [3:0] IDX_AMIN = 4'h8;
   localparam logic [3:0] IDX_AHOUR = 4'h9;
   localparam logic [3:0] IDX_ADATE = 4'hA;
   localparam logic [3:0] IDX_ADOW = 4'hB;
   localparam logic [3:0] IDX_CAL = 4'hC;
   localparam logic [3:0] IDX_SCR0 = 4'hD;
   localparam logic [3:0] IDX_SCR1 = 4'hE;
   localparam logic [3:0] IDX_SCR2 = 4'hF;

   // ------------------------------------------------------------------
   // Reset values, entry 15 down to entry 0 (2000-01-01 00:00:00)
   // ------------------------------------------------------------------
   localparam logic [15:0][7:0] ENTRY_RESET = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

   // ------------------------------------------------------------------
   // BCD limits
   // ------------------------------------------------------------------
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] SEC_MAX = 8'h59;
   localparam logic [7:0] HOUR_MAX = 8'h23;
   localparam logic [7:0] DOW_MAX = 8'h07;
   localparam logic [7:0] MONTH_MAX = 8'h12;
   localparam logic [7:0] YEAR_MAX = 8'h99;
   localparam logic [7:0] FEB = 8'h02;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_SYS_HZ = 50_000_000;
   localparam int OSC_HZ = 32_768;
   localparam int MS_PER_S = 1000;
   localparam int SUB_W = 15;
   localparam logic [SUB_W-1:0] SUB_TOP = 15'h7FFF;
   localparam logic [SUB_W:0] MS_STEP = 16'h03E8;
   localparam int WRITE_DELAY_TICKS = 2;
   localparam int MIN_CLK_RATIO = 3;

   // ------------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ALM_SEC, ALM_MIN, ALM_HOUR, ALM_DAY, ALM_WEEK
   } alarm_mode_t;

   typedef enum logic [2:0] {
      PER_MS, PER_SEC, PER_MIN, PER_HOUR, PER_DAY
   } period_sel_t;

   typedef struct packed {
      logic [3:0] index;
      logic [7:0] data;
   } write_req_t;

endpackage : rtc_pkg

`default_nettype wire

// *** src/bcd_rtc.sv ***
/*
 * BCD calendar clock with alarm, periodic event, calibration, scratch
 * entries and wake pin.  Assumes the crystal level osc_in is synchronous
 * to clk_sys_in, and that rst_n_in is the block's own power-on reset.
 */
`timescale 1ns/1ns
`default_nettype none

module bcd_rtc
   import rtc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic osc_in,
   input wire logic osc_en_in,
   input wire logic core_pwr_good_in,
   input wire logic wr_valid_in,
   input wire write_req_t wr_req_in,
   input wire logic [3:0] rd_index_in,
   output logic [7:0] rd_data_out,
   output logic wr_pending_out,
   input wire alarm_mode_t alarm_mode_in,
   input wire logic alarm_ie_in,
   input wire period_sel_t period_sel_in,
   input wire logic period_ie_in,
   input wire logic alarm_clr_in,
   input wire logic period_clr_in,
   output logic alarm_flag_out,
   output logic period_flag_out,
   output logic irq_out,
   input wire logic wake_dir_in,
   input wire logic wake_pin_in,
   output logic wake_pin_out,
   output logic wake_pin_oe_out,
   output logic wake_req_out
);

   // ------------------------------------------------------------------
   // BCD helpers
   // ------------------------------------------------------------------
   // Returns {wrap, next}; wraps from hi back to lo
   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
      logic [8:0] r;
      r = {1'b0, v};
      if (v == hi) begin
         r = {1'b1, lo};
      end else if (v[3:0] == 4'h9) begin
         r = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         r = {1'b0, v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction : bcd_inc

   // Every year of the century divisible by four is a leap year
   function automatic logic is_leap(input logic [7:0] y);
      logic r;
      r = 1'b0;
      if (!y[4]) begin
         r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end else begin
         r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
      return r;
   endfunction : is_leap

   function automatic logic [7:0] days_in(input logic [7:0] m, input logic leap);
      logic [7:0] r;
      r = 8'h31;
      case (m)
         8'h04, 8'h06, 8'h09, 8'h11: begin
            r = 8'h30;
         end
         FEB: begin
            r = leap ? 8'h29 : 8'h28;
         end
         default: begin
            r = 8'h31;
         end
      endcase
      return r;
   endfunction : days_in

   // ------------------------------------------------------------------
   // Crystal tick
   // ------------------------------------------------------------------
   logic osc_q;
   wire tick = osc_en_in & osc_in & ~osc_q;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         osc_q <= 1'b0;
      end else if (clk_en_in) begin
         osc_q <= osc_in;
      end
   end

   // ------------------------------------------------------------------
   // Value store and sub-second counting
   // ------------------------------------------------------------------
   logic [7:0] entry [NUM_ENTRIES];
   logic [7:0] next_entry [NUM_ENTRIES];
   logic [7:0] counted [NUM_ENTRIES];
   // One extra bit so a negative trim can stretch the last second
   logic [SUB_W:0] sub_cnt;
   logic [SUB_W-1:0] ms_acc;

   // Fractional accumulator: 1000 carries per 32768 ticks, no drift
   wire [SUB_W:0] ms_sum = {1'b0, ms_acc} + MS_STEP;
   wire ms_tick = tick & ms_sum[SUB_W];
   // Minute-end trim: a positive setting drops counts, negative adds
   wire signed [SUB_W+1:0] cal_ext = {{(SUB_W+2-8){entry[IDX_CAL][7]}}, entry[IDX_CAL]};
   wire signed [SUB_W+1:0] trimmed = $signed({2'b00, SUB_TOP}) - cal_ext;
   wire [SUB_W:0] sec_top = (entry[IDX_SEC] == SEC_MAX) ? trimmed[SUB_W:0]
                                                        : {1'b0, SUB_TOP};
   // At-or-past: a write to seconds can leave the counter beyond the top
   wire sec_tick = tick & (sub_cnt >= sec_top);
   wire [SUB_W:0] next_sub_cnt = sec_tick ? '0 : sub_cnt + 1'b1;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sub_cnt <= '0;
         ms_acc <= '0;
      end else if (clk_en_in && tick) begin
         sub_cnt <= next_sub_cnt;
         ms_acc <= ms_sum[SUB_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // Calendar carry chain
   // ------------------------------------------------------------------
   logic [8:0] sec_n, min_n, hour_n, dow_n, date_n, mon_n, year_n;
   logic [7:0] month_days;

   always_comb begin
      month_days = days_in(entry[IDX_MONTH], is_leap(entry[IDX_YEAR]));
      sec_n = bcd_inc(entry[IDX_SEC], BCD_ZERO, SEC_MAX);
      min_n = bcd_inc(entry[IDX_MIN], BCD_ZERO, SEC_MAX);
      hour_n = bcd_inc(entry[IDX_HOUR], BCD_ZERO, HOUR_MAX);
      dow_n = bcd_inc(entry[IDX_DOW], BCD_ONE, DOW_MAX);
      date_n = bcd_inc(entry[IDX_DATE], BCD_ONE, month_days);
      mon_n = bcd_inc(entry[IDX_MONTH], BCD_ONE, MONTH_MAX);
      year_n = bcd_inc(entry[IDX_YEAR], BCD_ZERO, YEAR_MAX);
   end

   wire min_carry = sec_tick & sec_n[8];
   wire hour_carry = min_carry & min_n[8];
   wire day_carry = hour_carry & hour_n[8];
   wire month_carry = day_carry & date_n[8];
   wire year_carry = month_carry & mon_n[8];

   always_comb begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
         counted[i] = entry[i];
      end
      if (sec_tick) begin
         counted[IDX_SEC] = sec_n[7:0];
      end
      if (min_carry) begin
         counted[IDX_MIN] = min_n[7:0];
      end
      if (hour_carry) begin
         counted[IDX_HOUR] = hour_n[7:0];
      end
      if (day_carry) begin
         counted[IDX_DOW] = dow_n[7:0];
         counted[IDX_DATE] = date_n[7:0];
      end
      if (month_carry) begin
         counted[IDX_MONTH] = mon_n[7:0];
      end
      if (year_carry) begin
         counted[IDX_YEAR] = year_n[7:0];
      end
   end

   // ------------------------------------------------------------------
   // Write capture and crystal-domain delay
   // ------------------------------------------------------------------
   // Core isolation and a stopped crystal both block the capture
   logic pend_valid;
   logic [1:0] pend_ticks;
   write_req_t pend_req;

   wire wr_take = wr_valid_in & osc_en_in & core_pwr_good_in;
   wire apply = pend_valid & tick & (pend_ticks == 2'(WRITE_DELAY_TICKS - 1));

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pend_valid <= 1'b0;
         pend_ticks <= '0;
         pend_req <= '0;
      end else if (clk_en_in) begin
         if (wr_take) begin
            pend_valid <= 1'b1;
            pend_ticks <= '0;
            pend_req <= wr_req_in;
         end else if (apply) begin
            pend_valid <= 1'b0;
         end else if (pend_valid && tick) begin
            pend_ticks <= pend_ticks + 1'b1;
         end
      end
   end

   // A late write overrides the count for that entry only
   for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_entry
      assign next_entry[g] = (apply && pend_req.index == 4'(g)) ? pend_req.data
                                                                : counted[g];
      always_ff @(posedge clk_sys_in) begin
         if (!rst_n_in) begin
            entry[g] <= ENTRY_RESET[g];
         end else if (clk_en_in) begin
            entry[g] <= next_entry[g];
         end
      end
   end

   // ------------------------------------------------------------------
   // Alarm match and periodic selection
   // ------------------------------------------------------------------
   logic sec_seen;
   wire m_sec = entry[IDX_SEC] == entry[IDX_ASEC];
   wire m_min = m_sec & (entry[IDX_MIN] == entry[IDX_AMIN]);
   wire m_hour = m_min & (entry[IDX_HOUR] == entry[IDX_AHOUR]);
   wire m_date = m_hour & (entry[IDX_DATE] == entry[IDX_ADATE]);
   wire m_dow = m_hour & (entry[IDX_DOW] == entry[IDX_ADOW]);
   logic alarm_hit;
   logic period_hit;

   always_comb begin
      case (alarm_mode_in)
         ALM_SEC: alarm_hit = m_sec;
         ALM_MIN: alarm_hit = m_min;
         ALM_HOUR: alarm_hit = m_hour;
         ALM_DAY: alarm_hit = m_date;
         ALM_WEEK: alarm_hit = m_dow;
         default: alarm_hit = 1'b0;
      endcase
      case (period_sel_in)
         PER_MS: period_hit = ms_tick;
         PER_SEC: period_hit = sec_tick;
         PER_MIN: period_hit = min_carry;
         PER_HOUR: period_hit = hour_carry;
         PER_DAY: period_hit = day_carry;
         default: period_hit = 1'b0;
      endcase
   end

   // Match is judged one cycle after the second advances
   wire alarm_event = sec_seen & alarm_hit;

   // ------------------------------------------------------------------
   // Flags, interrupt and wake
   // ------------------------------------------------------------------
   logic alarm_flag;
   logic period_flag;
   // Set beats a clear in the same cycle
   wire next_alarm_flag = alarm_event | (alarm_flag & ~alarm_clr_in);
   wire next_period_flag = period_hit | (period_flag & ~period_clr_in);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sec_seen <= 1'b0;
         alarm_flag <= 1'b0;
         period_flag <= 1'b0;
      end else if (clk_en_in) begin
         sec_seen <= sec_tick;
         alarm_flag <= next_alarm_flag;
         period_flag <= next_period_flag;
      end
   end

   // Registered read keeps the data output free of decode glitches
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rd_data_out <= '0;
      end else if (clk_en_in) begin
         rd_data_out <= entry[rd_index_in];
      end
   end

   wire any_event = (alarm_flag & alarm_ie_in) | (period_flag & period_ie_in);

   assign alarm_flag_out = alarm_flag;
   assign period_flag_out = period_flag;
   assign wr_pending_out = pend_valid;
   assign irq_out = any_event;
   // Open-drain: drive low only while an output and an event is pending
   assign wake_pin_out = 1'b0;
   assign wake_pin_oe_out = wake_dir_in & any_event;
   // Input wake only counts when the pin is configured as an input
   wire wake_in_req = ~wake_dir_in & wake_pin_in;
   assign wake_req_out = any_event | wake_in_req;

endmodule : bcd_rtc

`default_nettype wire

// *** test/bcd_rtc_properties.sv ***
/* Concurrent checks on the ports of the BCD calendar clock.
   Assumes one clock domain and a crystal tick at most every third clock. */
`timescale 1ns/1ns
`default_nettype none

module bcd_rtc_properties
   import rtc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic osc_en_in,
   input wire logic core_pwr_good_in,
   input wire logic wr_valid_in,
   input wire logic wr_pending_out,
   input wire logic alarm_ie_in,
   input wire logic period_ie_in,
   input wire logic alarm_clr_in,
   input wire logic period_clr_in,
   input wire logic alarm_flag_out,
   input wire logic period_flag_out,
   input wire logic irq_out,
   input wire logic wake_dir_in,
   input wire logic wake_pin_in,
   input wire logic wake_pin_out,
   input wire logic wake_pin_oe_out,
   input wire logic wake_req_out
);
   // Bound suits a fast test crystal only, not a real 32.768 kHz one
   localparam int MAX_WAIT = 1000;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   // ------------------------------------------------------------------
   // Write path
   // ------------------------------------------------------------------
   sequence s_capture;
      clk_en_in && wr_valid_in && osc_en_in && core_pwr_good_in;
   endsequence
   sequence s_refused;
      clk_en_in && wr_valid_in && !(osc_en_in && core_pwr_good_in) && !wr_pending_out;
   endsequence

   chk_write_taken: assert property (s_capture |=> wr_pending_out)
      else $error("write not captured");
   chk_write_refused: assert property (s_refused |=> !wr_pending_out)
      else $error("blocked write was captured");
   chk_apply_late: assert property ($rose(wr_pending_out) |-> wr_pending_out[*3])
      else $error("write applied before two ticks");
   chk_apply_bound: assert property ($rose(wr_pending_out) |-> ##[1:MAX_WAIT] !wr_pending_out)
      else $error("write never applied");

   // ------------------------------------------------------------------
   // Events and wake pin
   // ------------------------------------------------------------------
   chk_irq_merge: assert property (irq_out == ((alarm_flag_out && alarm_ie_in) ||
      (period_flag_out && period_ie_in))) else $error("interrupt not merge of flags");
   chk_wake_drive: assert property (wake_pin_oe_out == (wake_dir_in && irq_out))
      else $error("wake pin drive wrong");
   chk_wake_low: assert property (!wake_pin_out)
      else $error("wake pin driven high");
   chk_wake_req: assert property (wake_req_out == (irq_out || (!wake_dir_in && wake_pin_in)))
      else $error("wake request wrong");
   chk_alarm_sticky: assert property ($fell(alarm_flag_out) |-> $past(alarm_clr_in))
      else $error("alarm flag dropped without clear");
   chk_period_sticky: assert property ($fell(period_flag_out) |-> $past(period_clr_in))
      else $error("period flag dropped without clear");
   chk_pwr_keep: assert property (!core_pwr_good_in && alarm_flag_out && !alarm_clr_in
      |=> alarm_flag_out) else $error("core power loss touched flag");
endmodule : bcd_rtc_properties

bind bcd_rtc bcd_rtc_properties u_props (.clk_sys_in, .rst_n_in, .clk_en_in, .osc_en_in,
   .core_pwr_good_in, .wr_valid_in, .wr_pending_out, .alarm_ie_in, .period_ie_in,
   .alarm_clr_in, .period_clr_in, .alarm_flag_out, .period_flag_out, .irq_out, .wake_dir_in,
   .wake_pin_in, .wake_pin_out, .wake_pin_oe_out, .wake_req_out);

`default_nettype wire

// *** test/bcd_rtc_tb_top.sv ***
/* Self-checking bench for the BCD calendar clock.
   Assumes the crystal level is made here, one tick every third clock. */
`timescale 1ns/1ns
`default_nettype none

module bcd_rtc_tb_top;
   import rtc_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_n_in, clk_en_in, osc_en_in, core_pwr_good_in, wr_valid_in;
   logic osc_in = 1'b0;
   logic osc_q = 1'b0;
   write_req_t wr_req_in;
   logic [3:0] rd_index_in;
   logic [7:0] rd_data_out;
   alarm_mode_t alarm_mode_in;
   period_sel_t period_sel_in;
   logic alarm_ie_in, period_ie_in, alarm_clr_in, period_clr_in, wake_dir_in, wake_pin_in;
   logic wr_pending_out, alarm_flag_out, period_flag_out, irq_out;
   logic wake_pin_out, wake_pin_oe_out, wake_req_out;
   int num_errors = 0, comparisons = 0, cycles = 0, ticks = 0, phase = 0;

   bcd_rtc dut (.clk_sys_in, .rst_n_in, .clk_en_in, .osc_in, .osc_en_in, .core_pwr_good_in,
      .wr_valid_in, .wr_req_in, .rd_index_in, .rd_data_out, .wr_pending_out, .alarm_mode_in,
      .alarm_ie_in, .period_sel_in, .period_ie_in, .alarm_clr_in, .period_clr_in,
      .alarm_flag_out, .period_flag_out, .irq_out, .wake_dir_in, .wake_pin_in, .wake_pin_out,
      .wake_pin_oe_out, .wake_req_out);

   // ------------------------------------------------------------------
   // Clock, crystal and watchdog
   // ------------------------------------------------------------------
   initial forever #10 clk_sys_in = ~clk_sys_in;

   always @(negedge clk_sys_in) begin
      phase = (phase == 2) ? 0 : phase + 1;
      osc_in = (phase == 0);
   end

   // Long hang guard: the full-calendar rollover alone needs about 98k cycles
   always @(posedge clk_sys_in) begin
      osc_q <= osc_in;
      if (osc_in && !osc_q) ticks <= ticks + 1;
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         num_errors++;
         complete_run();
      end
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic flag(input logic got, input logic exp);
      check({7'h00, got}, {7'h00, exp});
   endtask : flag

   task automatic wr(input logic [3:0] idx, input logic [7:0] val);
      @(negedge clk_sys_in);
      wr_valid_in = 1'b1;
      wr_req_in = '{index: idx, data: val};
      @(negedge clk_sys_in);
      wr_valid_in = 1'b0;
   endtask : wr

   task automatic settle;
      int n;
      n = 0;
      while (wr_pending_out !== 1'b0 && n < 50) begin
         @(negedge clk_sys_in);
         n++;
      end
      flag(wr_pending_out, 1'b0);
   endtask : settle

   task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
      @(negedge clk_sys_in);
      rd_index_in = idx;
      @(negedge clk_sys_in);
      check(rd_data_out, exp);
   endtask : rd

   task automatic complete_run;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset_values;
      for (int i = 0; i < NUM_ENTRIES; i++) rd(i[3:0], ENTRY_RESET[i]);
      flag(alarm_flag_out | period_flag_out, 1'b0);
   endtask : t_reset_values

   task automatic t_write_delay;
      int t0;
      wr(IDX_SCR0, 8'hA5);
      t0 = ticks;
      flag(wr_pending_out, 1'b1);
      rd(IDX_SCR0, 8'h00);
      settle();
      flag((ticks - t0) inside {2, 3}, 1'b1);
      rd(IDX_SCR0, 8'hA5);
      wr_valid_in = 1'b1;
      wr_req_in = '{index: IDX_SCR1, data: 8'h11};
      @(negedge clk_sys_in);
      wr_req_in = '{index: IDX_SCR1, data: 8'h22};
      @(negedge clk_sys_in);
      wr_valid_in = 1'b0;
      settle();
      rd(IDX_SCR1, 8'h22);
   endtask : t_write_delay

   task automatic t_refused;
      osc_en_in = 1'b0;
      wr(IDX_SCR2, 8'h3C);
      osc_en_in = 1'b1;
      core_pwr_good_in = 1'b0;
      wr(IDX_SCR2, 8'h5A);
      core_pwr_good_in = 1'b1;
      clk_en_in = 1'b0;
      wr(IDX_SCR2, 8'h77);
      clk_en_in = 1'b1;
      repeat (12) @(negedge clk_sys_in);
      rd(IDX_SCR2, 8'h00);
      rd(IDX_SCR0, 8'hA5);
   endtask : t_refused

   task automatic t_periodic;
      int n;
      period_sel_in = PER_MS;
      n = 0;
      while (period_flag_out !== 1'b1 && n < 200) begin
         @(negedge clk_sys_in);
         n++;
      end
      flag(period_flag_out, 1'b1);
      flag(irq_out, 1'b0);
      period_ie_in = 1'b1;
      wake_dir_in = 1'b1;
      @(negedge clk_sys_in);
      flag(irq_out, 1'b1);
      flag(wake_pin_oe_out, 1'b1);
      flag(wake_pin_out, 1'b0);
      period_sel_in = PER_DAY;
      period_clr_in = 1'b1;
      @(negedge clk_sys_in);
      period_clr_in = 1'b0;
      flag(period_flag_out, 1'b0);
      flag(wake_pin_oe_out, 1'b0);
      wake_dir_in = 1'b0;
      wake_pin_in = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      flag(wake_req_out, 1'b1);
      wake_dir_in = 1'b1;
      @(negedge clk_sys_in);
      flag(wake_req_out, 1'b0);
      wake_pin_in = 1'b0;
   endtask : t_periodic

   task automatic t_rollover;
      logic [6:0][7:0] set_v, end_v;
      int n;
      set_v = {8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59};
      end_v = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
      alarm_mode_in = ALM_DAY;
      alarm_ie_in = 1'b1;
      wr(IDX_CAL, 8'h7F);
      settle();
      for (int i = 6; i >= 0; i--) begin
         wr(i[3:0], set_v[i]);
         settle();
      end
      rd(IDX_DATE, 8'h31);
      flag(alarm_flag_out, 1'b0);
      rd_index_in = IDX_SEC;
      n = 0;
      while (rd_data_out !== 8'h00 && n < 110000) begin
         @(negedge clk_sys_in);
         n++;
      end
      repeat (3) @(negedge clk_sys_in);
      flag(alarm_flag_out, 1'b1);
      flag(period_flag_out, 1'b1);
      flag(irq_out, 1'b1);
      core_pwr_good_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      core_pwr_good_in = 1'b1;
      flag(alarm_flag_out, 1'b1);
      for (int i = 0; i < 7; i++) rd(i[3:0], end_v[i]);
      alarm_clr_in = 1'b1;
      @(negedge clk_sys_in);
      alarm_clr_in = 1'b0;
      flag(alarm_flag_out, 1'b0);
      flag(irq_out, 1'b1);
   endtask : t_rollover

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      rst_n_in = 1'b0;
      clk_en_in = 1'b1;
      osc_en_in = 1'b1;
      core_pwr_good_in = 1'b1;
      wr_valid_in = 1'b0;
      wr_req_in = '0;
      rd_index_in = 4'h0;
      alarm_mode_in = ALM_SEC;
      period_sel_in = PER_DAY;
      {alarm_ie_in, period_ie_in, alarm_clr_in, period_clr_in} = 4'h0;
      {wake_dir_in, wake_pin_in} = 2'h0;
      repeat (2) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      t_reset_values();
      t_write_delay();
      t_refused();
      t_periodic();
      t_rollover();
      complete_run();
   end
endmodule : bcd_rtc_tb_top

`default_nettype wire
